// file: pressure_result_fifo_slope_bench.sv
// Purpose: self-checking bench of the result store and slope detector
// Assumes: fixed latencies of the design, samples 32 cycles apart
// Notes:   expectations come from register map and slope arithmetic
`timescale 1ns/10ps
`default_nettype none
`include "prs_params.svh"

module pressure_result_fifo_slope_bench;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [15:0] reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        pressure_valid_in = 1'b0;
  logic [15:0] pressure_in = 16'h0000;
  logic        temp_valid_in = 1'b0;
  logic [7:0]  temp_code_in = 8'h00;
  logic        volt_valid_in = 1'b0;
  logic [7:0]  volt_code_in = 8'h00;
  logic        enable_in = 1'b0;
  logic        clear_in = 1'b0;
  logic        flag_out;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [15:0] p_hist [0:11];
  logic [15:0] p;
  logic [7:0]  idx;

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  prs_host_model prs_host_model_inst (
    .clk_in        (clk_in),
    .reg_addr_out  (reg_addr),
    .reg_wr_out    (reg_wr),
    .reg_wdata_out (reg_wdata),
    .reg_rd_out    (reg_rd),
    .reg_rdata_in  (reg_rdata)
  );

  prs_result_store prs_result_store_inst (
    .clk_in                  (clk_in),
    .arst_n_in               (arst_n_in),
    .reg_addr_in             (reg_addr),
    .reg_wr_in               (reg_wr),
    .reg_wdata_in            (reg_wdata),
    .reg_rd_in               (reg_rd),
    .reg_rdata_out           (reg_rdata),
    .pressure_valid_in       (pressure_valid_in),
    .pressure_in             (pressure_in),
    .temp_valid_in           (temp_valid_in),
    .temp_code_in            (temp_code_in),
    .volt_valid_in           (volt_valid_in),
    .volt_code_in            (volt_code_in),
    .slope_detect_enable_in  (enable_in),
    .slope_flag_clear_in     (clear_in),
    .slope_exceeded_flag_out (flag_out)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    prs_host_model_inst.rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  task automatic flag_chk(input logic exp);
    chk({15'h0000, flag_out}, {15'h0000, exp});
  endtask : flag_chk

  // one sample strobe, then time for the divider and the flag to settle
  task automatic sample(input logic [15:0] v);
    @(posedge clk_in);
    #1;
    pressure_valid_in = 1'b1;
    pressure_in       = v;
    @(posedge clk_in);
    #1;
    pressure_valid_in = 1'b0;
    pressure_in       = ~v;
    repeat (30) @(posedge clk_in);
  endtask : sample

  task automatic set_thr(input logic [15:0] v);
    prs_host_model_inst.wr(`PRS_ADDR_THR_HI, v[15:8]);
    prs_host_model_inst.wr(`PRS_ADDR_THR_LO, v[7:0]);
    rd_chk(`PRS_ADDR_THR_HI, v[15:8]);
    rd_chk(`PRS_ADDR_THR_LO, v[7:0]);
  endtask : set_thr

  task automatic clear_flag();
    @(posedge clk_in);
    #1;
    clear_in = 1'b1;
    @(posedge clk_in);
    #1;
    clear_in = 1'b0;
    flag_chk(1'b0);
  endtask : clear_flag

  task automatic check_reset_state();
    flag_chk(1'b0);
    rd_chk(`PRS_ADDR_TEMP, 8'h00);
    rd_chk(`PRS_ADDR_VOLT, 8'h00);
    rd_chk(`PRS_ADDR_INDEX, 8'h76);
    rd_chk(`PRS_ADDR_THR_HI, 8'h00);
    rd_chk(`PRS_ADDR_THR_LO, 8'h40);
    for (int i = 0; i < 24; i++) begin
      rd_chk(`PRS_ADDR_HIST_BASE + 16'(i), 8'h00);
    end
  endtask : check_reset_state

  // bound on the whole run
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    $display("run limit reached");
    conclude();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    check_reset_state();
    // writes to read-only places and an unmapped read
    prs_host_model_inst.wr(`PRS_ADDR_TEMP, 8'h5a);
    prs_host_model_inst.wr(`PRS_ADDR_HIST_BASE, 8'h5a);
    prs_host_model_inst.wr(`PRS_ADDR_INDEX, 8'h5a);
    rd_chk(`PRS_ADDR_TEMP, 8'h00);
    rd_chk(`PRS_ADDR_HIST_BASE, 8'h00);
    rd_chk(`PRS_ADDR_INDEX, 8'h76);
    rd_chk(16'h0072, 8'h00);
    // back-to-back temperature and voltage strobes, last one kept
    @(posedge clk_in);
    #1;
    temp_valid_in = 1'b1;
    temp_code_in  = 8'h37;
    volt_valid_in = 1'b1;
    volt_code_in  = 8'h80;
    @(posedge clk_in);
    #1;
    temp_code_in  = 8'hc8;
    volt_code_in  = 8'h4b;
    @(posedge clk_in);
    #1;
    temp_valid_in = 1'b0;
    volt_valid_in = 1'b0;
    temp_code_in  = 8'h37;
    volt_code_in  = 8'hb4;
    rd_chk(`PRS_ADDR_TEMP, 8'hc8);
    rd_chk(`PRS_ADDR_VOLT, 8'h4b);
    // thirteen falling samples, one wrap of the history
    for (int k = 0; k < 13; k++) begin
      p = 16'h1000 - 16'(k) * 16'h0111;
      p_hist[k % 12] = p;
      idx = 8'h77 + 8'(2 * (k % 12));
      sample(p);
      rd_chk(`PRS_ADDR_INDEX, idx);
    end
    for (int e = 0; e < 12; e++) begin
      p = `PRS_ADDR_HIST_BASE + 16'(2 * e);
      rd_chk(p, p_hist[e][15:8]);
      rd_chk(p + 16'h0001, p_hist[e][7:0]);
    end
    // slope at threshold stays quiet, above it raises the flag
    set_thr(16'd640);
    enable_in = 1'b1;
    sample(16'd100);
    sample(16'd110);
    flag_chk(1'b0);
    sample(16'd120);
    flag_chk(1'b1);
    clear_flag();
    // longer rising chain divides by the period count plus one
    set_thr(16'd853);
    sample(16'd90);
    sample(16'd100);
    sample(16'd110);
    flag_chk(1'b0);
    sample(16'd120);
    flag_chk(1'b1);
    clear_flag();
    // clear held high across a set: the set wins, then the clear acts
    @(posedge clk_in);
    #1;
    clear_in = 1'b1;
    @(posedge clk_in);
    #1;
    pressure_valid_in = 1'b1;
    pressure_in       = 16'd130;
    @(posedge clk_in);
    #1;
    pressure_valid_in = 1'b0;
    pressure_in       = ~16'd130;
    repeat (23) @(posedge clk_in);
    #1;
    flag_chk(1'b0);
    @(posedge clk_in);
    #1;
    flag_chk(1'b1);
    @(posedge clk_in);
    #1;
    clear_in = 1'b0;
    flag_chk(1'b0);
    // steep rise with detection disabled
    enable_in = 1'b0;
    sample(16'd50);
    sample(16'd200);
    flag_chk(1'b0);
    // second reset in mid-run restores every reset value again
    @(posedge clk_in);
    #1;
    arst_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    check_reset_state();
    conclude();
  end
endmodule : pressure_result_fifo_slope_bench
`default_nettype wire

// file: prs_divider.sv
// Purpose: unsigned restoring divider, one quotient bit per cycle
// Assumes: start only while busy_out is low
// Notes:   quotient valid when done_out pulses, held until next start
`timescale 1ns/10ps
`default_nettype none

module prs_divider #(
  parameter int DW = 23,
  parameter int VW = 8
) (
  input  wire logic          clk_in,
  input  wire logic          arst_n_in,
  input  wire logic          start_in,
  input  wire logic [DW-1:0] dividend_in,
  input  wire logic [VW-1:0] divisor_in,
  output logic               busy_out,
  output logic               done_out,
  output logic [DW-1:0]      quot_out
);

  if (DW < 2 || VW < 1) begin : g_bad_width
    $error("prs_divider: widths too small");
  end

  localparam int CW = $clog2(DW + 1);

  prs_pkg::prs_div_state_t state_r;
  logic [DW-1:0]           work_r;
  logic [VW:0]             rem_r;
  logic [VW-1:0]           dvs_r;
  logic [CW-1:0]           cnt_r;
  wire  [VW:0]             rem_shift;
  wire                     fits;
  wire  [VW:0]             rem_sub;

  // ----------------------------------------------------------------------
  // one restoring step
  // ----------------------------------------------------------------------
  assign rem_shift = {rem_r[VW-1:0], work_r[DW-1]};
  assign fits      = rem_shift >= {1'b0, dvs_r};
  assign rem_sub   = rem_shift - {1'b0, dvs_r};
  assign busy_out  = state_r == prs_pkg::DIV_RUN;
  assign done_out  = state_r == prs_pkg::DIV_DONE;
  assign quot_out  = work_r;

  // sequencer and datapath
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= prs_pkg::DIV_IDLE;
      work_r  <= '0;
      rem_r   <= '0;
      dvs_r   <= '0;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        prs_pkg::DIV_IDLE, prs_pkg::DIV_DONE: begin
          state_r <= prs_pkg::DIV_IDLE;
          if (start_in) begin
            state_r <= prs_pkg::DIV_RUN;
            work_r  <= dividend_in;
            dvs_r   <= divisor_in;
            rem_r   <= '0;
            cnt_r   <= CW'(DW - 1);
          end
        end
        prs_pkg::DIV_RUN: begin
          rem_r  <= fits ? rem_sub : rem_shift;
          work_r <= {work_r[DW-2:0], fits};
          cnt_r  <= cnt_r - 1'b1;
          if (cnt_r == '0) begin
            state_r <= prs_pkg::DIV_DONE;
          end
        end
        default: begin
          state_r <= prs_pkg::DIV_IDLE;
        end
      endcase
    end
  end

endmodule : prs_divider
`default_nettype wire

// file: prs_host_model.sv
// Purpose: host side of the byte register port, one access per task call
// Assumes: strobes are sampled on the rising edge of clk_in
// Notes:   released address and data lines show the inverse of last value
`timescale 1ns/10ps
`default_nettype none

module prs_host_model (
  input  wire logic        clk_in,
  output logic      [15:0] reg_addr_out,
  output logic             reg_wr_out,
  output logic      [7:0]  reg_wdata_out,
  output logic             reg_rd_out,
  input  wire logic [7:0]  reg_rdata_in
);
  // idle bus at time zero
  initial begin
    reg_addr_out  = 16'h0000;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out    = 1'b0;
  end

  // one-cycle write strobe, lines scrambled once released
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(posedge clk_in);
    #1;
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~d;
  endtask : wr

  // one-cycle read strobe, byte taken once the edge has updated it
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(posedge clk_in);
    #1;
    d            = reg_rdata_in;
    reg_rd_out   = 1'b0;
    reg_addr_out = ~a;
  endtask : rd
endmodule : prs_host_model
`default_nettype wire

// file: prs_params.svh
// Purpose: offsets, reset values and slope arithmetic constants of the result store
// Assumes: byte-wide registers behind a 16-bit register address
// Notes:   definitions only
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define PRS_ADDR_THR_HI    16'h005e
`define PRS_ADDR_THR_LO    16'h005f
`define PRS_ADDR_TEMP      16'h0070
`define PRS_ADDR_VOLT      16'h0071
`define PRS_ADDR_INDEX     16'h0075
`define PRS_ADDR_HIST_BASE 16'h0076
`define PRS_ADDR_HIST_LAST 16'h008d

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PRS_RST_THR        16'h0040
`define PRS_RST_TEMP       8'h00
`define PRS_RST_VOLT       8'h00
`define PRS_RST_INDEX      8'h76
`define PRS_RST_HIST       16'h0000
`define PRS_RST_RDATA      8'h00

// ----------------------------------------------------------------------
// slope arithmetic
// ----------------------------------------------------------------------
`define PRS_SLOPE_SHIFT    7
`define PRS_RISE_MAX       8'hfe
`define PRS_HIST_DEPTH     12
`define PRS_DIV_MAX_CYC    30

`endif

// file: prs_pkg.sv
// Purpose: types shared by the result store files
// Assumes: nothing
// Notes:   constants live in prs_params.svh
package prs_pkg;

  // ----------------------------------------------------------------------
  // divider sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DIV_IDLE,
    DIV_RUN,
    DIV_DONE
  } prs_div_state_t;

endpackage : prs_pkg

// file: prs_result_store.sv
// Purpose: slope detection and measurement result registers
// Assumes: byte register port decoded by the serial front end
// Notes:   one pressure sample per sampling period on pressure_valid_in
//
// What this block does
// - with slope detect enabled, set flag when slope exceeds threshold
// - slope is rise in counts times 128 over rising periods plus one
// - period count is consecutive rising samples up to evaluation
// - read-only temperature byte, replaced on each new measurement
// - temperature code means degrees Celsius plus 55, stored as given
// - read-only voltage byte, replaced on each new measurement
// - voltage code means (volts minus 1.22) over 0.01, stored as given
// - read-only index byte holds address of last history byte written
// - history keeps the twelve latest 16-bit pressure samples
// - history is circular, newest sample overwrites the oldest
// - each entry uses two addresses, high byte first, low byte next
// - history mapped read-only at 0x76 to 0x8d, zero after reset
// - slope threshold writable, high byte 0x5e, low byte 0x5f
`timescale 1ns/10ps
`default_nettype none
`include "prs_params.svh"

module prs_result_store #(
  parameter int DEPTH = `PRS_HIST_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        pressure_valid_in,
  input  wire logic [15:0] pressure_in,
  input  wire logic        temp_valid_in,
  input  wire logic [7:0]  temp_code_in,
  input  wire logic        volt_valid_in,
  input  wire logic [7:0]  volt_code_in,
  input  wire logic        slope_detect_enable_in,
  input  wire logic        slope_flag_clear_in,
  output logic             slope_exceeded_flag_out
);

  if (DEPTH < 2 || DEPTH > `PRS_HIST_DEPTH) begin : g_bad_depth
    $error("prs_result_store: DEPTH must be 2 to 12");
  end

  localparam int PW = $clog2(DEPTH);
  localparam int DW = 16 + `PRS_SLOPE_SHIFT;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [15:0]   hist_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [7:0]    hist_index_r;
  logic [15:0]   slope_threshold_r;
  logic [7:0]    temperature_result_r;
  logic [7:0]    voltage_result_r;
  logic [7:0]    rdata_r;
  logic [15:0]   prev_p_r;
  logic [15:0]   base_p_r;
  logic [7:0]    rise_cnt_r;
  logic          have_prev_r;
  logic          flag_r;

  // ----------------------------------------------------------------------
  // slope datapath
  // ----------------------------------------------------------------------
  wire           rising;
  wire  [7:0]    rise_cnt_nxt;
  wire  [15:0]   delta;
  wire           div_busy;
  wire           div_done;
  wire  [DW-1:0] div_quot;
  wire           div_start;
  wire  [DW-1:0] div_dividend;
  wire  [7:0]    div_divisor;
  wire           slope_over;
  wire           flag_set;

  // rising chain length and the rise since the chain began
  assign rising       = have_prev_r && (pressure_in > prev_p_r);
  assign rise_cnt_nxt = (rise_cnt_r == `PRS_RISE_MAX) ? rise_cnt_r
                        : rise_cnt_r + 8'h01;
  assign delta        = pressure_in - base_p_r;
  // a sample during a running division is not evaluated
  assign div_start    = pressure_valid_in && rising && !div_busy
                        && slope_detect_enable_in;
  assign div_dividend = {delta, 7'h00};
  assign div_divisor  = rise_cnt_nxt + 8'h01;
  assign slope_over   = div_quot > {7'h00, slope_threshold_r};
  assign flag_set     = div_done && slope_detect_enable_in
                        && slope_over;

  prs_divider #(
    .DW (DW),
    .VW (8)
  ) prs_divider_inst (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .start_in    (div_start),
    .dividend_in (div_dividend),
    .divisor_in  (div_divisor),
    .busy_out    (div_busy),
    .done_out    (div_done),
    .quot_out    (div_quot)
  );

  // rise tracking per pressure sample
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_p_r    <= 16'h0000;
      base_p_r    <= 16'h0000;
      rise_cnt_r  <= 8'h00;
      have_prev_r <= 1'b0;
    end else if (pressure_valid_in) begin
      prev_p_r    <= pressure_in;
      have_prev_r <= 1'b1;
      rise_cnt_r  <= rising ? rise_cnt_nxt : 8'h00;
      if (!rising) begin
        base_p_r <= pressure_in;
      end
    end
  end

  // sticky flag, a set in the clearing cycle wins
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_set || (flag_r && !slope_flag_clear_in);
    end
  end

  assign slope_exceeded_flag_out = flag_r;

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  wire  [15:0]   hoff;
  wire           hit_hist;
  wire  [PW-1:0] rd_entry;
  wire  [7:0]    hist_byte;
  wire  [7:0]    index_nxt;
  wire  [PW-1:0] ptr_nxt;
  logic [7:0]    rd_mux;

  assign hoff      = reg_addr_in - `PRS_ADDR_HIST_BASE;
  assign hit_hist  = (reg_addr_in >= `PRS_ADDR_HIST_BASE)
                     && (hoff < 16'(2 * DEPTH));
  assign rd_entry  = hoff[PW:1];
  assign hist_byte = hoff[0] ? hist_r[rd_entry][7:0]
                     : hist_r[rd_entry][15:8];
  assign index_nxt = `PRS_RST_INDEX + 8'h01
                     + {{(7-PW){1'b0}}, wr_ptr_r, 1'b0};
  assign ptr_nxt   = (wr_ptr_r == PW'(DEPTH - 1)) ? '0
                     : wr_ptr_r + 1'b1;

  // read data select, unmapped addresses read zero
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr_in == `PRS_ADDR_THR_HI) begin
      rd_mux = slope_threshold_r[15:8];
    end else if (reg_addr_in == `PRS_ADDR_THR_LO) begin
      rd_mux = slope_threshold_r[7:0];
    end else if (reg_addr_in == `PRS_ADDR_TEMP) begin
      rd_mux = temperature_result_r;
    end else if (reg_addr_in == `PRS_ADDR_VOLT) begin
      rd_mux = voltage_result_r;
    end else if (reg_addr_in == `PRS_ADDR_INDEX) begin
      rd_mux = hist_index_r;
    end else if (hit_hist) begin
      rd_mux = hist_byte;
    end
  end

  // registered read data
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= `PRS_RST_RDATA;
    end else if (reg_rd_in) begin
      rdata_r <= rd_mux;
    end
  end

  assign reg_rdata_out = rdata_r;

  // threshold bytes, the only writable registers here
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slope_threshold_r <= `PRS_RST_THR;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `PRS_ADDR_THR_HI) begin
        slope_threshold_r[15:8] <= reg_wdata_in;
      end
      if (reg_addr_in == `PRS_ADDR_THR_LO) begin
        slope_threshold_r[7:0] <= reg_wdata_in;
      end
    end
  end

  // compensated codes are stored verbatim, encodings are the producer's
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      temperature_result_r <= `PRS_RST_TEMP;
      voltage_result_r     <= `PRS_RST_VOLT;
    end else begin
      if (temp_valid_in) begin
        temperature_result_r <= temp_code_in;
      end
      if (volt_valid_in) begin
        voltage_result_r <= volt_code_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // rolling history
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r     <= '0;
      hist_index_r <= `PRS_RST_INDEX;
    end else if (pressure_valid_in) begin
      wr_ptr_r     <= ptr_nxt;
      hist_index_r <= index_nxt;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_hist
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        hist_r[i] <= `PRS_RST_HIST;
      end else if (pressure_valid_in && wr_ptr_r == PW'(i)) begin
        hist_r[i] <= pressure_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  localparam int DIV_MAX_CYC = `PRS_DIV_MAX_CYC;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  chk_flag_sets: assert property (
    flag_set |=> slope_exceeded_flag_out)
    else $error("slope flag not set after exceeding slope");

  chk_flag_cause: assert property (
    $rose(slope_exceeded_flag_out) |-> $past(div_done)
    && $past(div_quot) > {7'h00, $past(slope_threshold_r)})
    else $error("slope flag rose without exceeding slope");

  chk_div_finish: assert property (
    div_start |-> ##[1:DIV_MAX_CYC] div_done)
    else $error("slope division did not finish");

  // done comes exactly DW + 1 edges after start, so the operands are
  // taken that far back; quotient times divisor must not pass the
  // dividend and must leave a remainder below the divisor
  chk_div_value: assert property (
    div_done |-> 32'(div_quot) * 32'($past(div_divisor, DW + 1))
    <= 32'($past(div_dividend, DW + 1))
    && 32'($past(div_dividend, DW + 1))
    - 32'(div_quot) * 32'($past(div_divisor, DW + 1))
    < 32'($past(div_divisor, DW + 1)))
    else $error("slope quotient wrong");

  chk_rise_reset: assert property (
    pressure_valid_in && !rising |=> rise_cnt_r == 8'h00)
    else $error("rise count not cleared on non rising sample");

  chk_rise_step: assert property (
    pressure_valid_in && rising && rise_cnt_r < `PRS_RISE_MAX
    |=> rise_cnt_r == $past(rise_cnt_r) + 8'h01)
    else $error("rise count did not step");

  chk_temp_update: assert property (
    temp_valid_in |=> temperature_result_r == $past(temp_code_in))
    else $error("temperature result not replaced");

  chk_volt_update: assert property (
    volt_valid_in |=> voltage_result_r == $past(volt_code_in))
    else $error("voltage result not replaced");

  chk_index_low: assert property (
    pressure_valid_in |=> hist_index_r
    == 8'h77 + {{(7-PW){1'b0}}, $past(wr_ptr_r), 1'b0})
    else $error("index not on low byte of written entry");

  chk_ptr_wrap: assert property (
    pressure_valid_in && wr_ptr_r == PW'(DEPTH - 1) |=> wr_ptr_r == '0)
    else $error("history pointer did not wrap");

  chk_entry_store: assert property (
    pressure_valid_in |=> hist_r[$past(wr_ptr_r)] == $past(pressure_in))
    else $error("history entry not stored");

  chk_hist_high: assert property (
    reg_rd_in && reg_addr_in == `PRS_ADDR_HIST_BASE && !pressure_valid_in
    |=> reg_rdata_out == hist_r[0][15:8])
    else $error("history high byte not first");

  chk_thr_write: assert property (
    reg_wr_in && reg_addr_in == `PRS_ADDR_THR_LO
    |=> slope_threshold_r[7:0] == $past(reg_wdata_in))
    else $error("threshold low byte not written");

  cov_flag_rise:  cover property ($rose(slope_exceeded_flag_out));
  cov_hist_wrap:  cover property (pressure_valid_in
                                  && wr_ptr_r == PW'(DEPTH - 1));
  cov_hist_read:  cover property (reg_rd_in && hit_hist);
  cov_set_clear:  cover property (flag_set && slope_flag_clear_in);

endmodule : prs_result_store
`default_nettype wire
